// [eas_pkg.sv]
// Constants for exception acceptance and stacking.
// Assumes a 32-bit address space and 16-bit instruction codes.
package eas_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          OP_W          = 16;
    localparam logic [31:0] STACK_STEP    = 32'h0000_0004;
    localparam logic [31:0] VEC_ENTRY     = 32'h0000_0004;
    localparam logic [1:0]  ALIGN_MASK    = 2'h3;
    localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
    localparam logic [7:0]  ADDR_ERR_VEC  = 8'h09;
    localparam int          SHORT_LOOP    = 3;
    localparam logic [7:0]  MIN_LOOP_LEN  = 8'h04;
    localparam logic [7:0]  TAIL_LAST     = 8'h03;
    localparam logic [7:0]  ADDR_ONLY_POS = 8'h04;
    // Exception kinds
    localparam logic [2:0]  KIND_ADDR_ERR = 3'h0;
    localparam logic [2:0]  KIND_IRQ      = 3'h1;
    localparam logic [2:0]  KIND_TRAP     = 3'h2;
    localparam logic [2:0]  KIND_ILLEGAL  = 3'h3;
    localparam logic [2:0]  KIND_SLOT     = 3'h4;
    typedef enum logic [5:0] {
        EAS_IDLE      = 6'h01,
        EAS_PUSH_STAT = 6'h02,
        EAS_PUSH_PC   = 6'h04,
        EAS_VEC_READ  = 6'h08,
        EAS_JUMP      = 6'h10,
        EAS_DONE      = 6'h20
    } eas_state_t;
endpackage

// [eas_gate_if.sv]
`timescale 1ns/100ps
// Carries the decoded instruction's acceptance decision.
// Assumes the decoder presents one classified instruction per strobe.
interface eas_gate_if;
    logic decode_valid;
    logic is_delayed_branch;
    logic is_int_disabled;
    logic [7:0] loop_len;
    logic [7:0] loop_pos_from_end;
    logic in_loop;
    logic block_addr_err;
    logic block_irq;
    modport gate (
        input  decode_valid, is_delayed_branch, is_int_disabled,
        input  loop_len, loop_pos_from_end, in_loop,
        output block_addr_err, block_irq
    );
    modport core (
        output decode_valid, is_delayed_branch, is_int_disabled,
        output loop_len, loop_pos_from_end, in_loop,
        input  block_addr_err, block_irq
    );
endinterface

// [eas_accept_gate.sv]
`timescale 1ns/100ps
// Acceptance gate: decides per decoded instruction what may be taken.
// Assumes one classified instruction per decode strobe.
module eas_accept_gate (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic clk_en_in,
    // Decode side
    eas_gate_if.gate  gate_io
);
    logic next_block_ae;
    logic next_block_irq;

    // Class of this decode guards the decode that follows it
    always_comb begin
        next_block_ae  = 1'b0;
        next_block_irq = 1'b0;
        if (gate_io.is_delayed_branch) begin
            next_block_ae  = 1'b1;
            next_block_irq = 1'b1;
        end
        if (gate_io.is_int_disabled) begin
            next_block_irq = 1'b1;
        end
        if (gate_io.in_loop) begin
            if (gate_io.loop_len < eas_pkg::MIN_LOOP_LEN) begin
                next_block_ae  = 1'b1;
                next_block_irq = 1'b1;
            end else if (gate_io.loop_pos_from_end == gate_io.loop_len ||
                         gate_io.loop_pos_from_end <= eas_pkg::TAIL_LAST)
            begin
                next_block_ae  = 1'b1;
                next_block_irq = 1'b1;
            end else if (gate_io.loop_pos_from_end ==
                         eas_pkg::ADDR_ONLY_POS) begin
                next_block_irq = 1'b1;
            end
        end
    end

    // Decision sampled once per decoded instruction
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            gate_io.block_addr_err <= 1'b1;
            gate_io.block_irq      <= 1'b1;
        end else if (clk_en_in && gate_io.decode_valid) begin
            gate_io.block_addr_err <= next_block_ae;
            gate_io.block_irq      <= next_block_irq;
        end
    end
endmodule

// [eas_exception_unit.sv]
`timescale 1ns/100ps
// Exception acceptance and stacking sequencer for the CPU core.
// Assumes a single-cycle write/read bus with a one-cycle read strobe.

module eas_exception_unit #(
    parameter int ADDR_W = eas_pkg::ADDR_W
) (
    // Clock, reset, enable
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              clk_en_in,
    // Decoded instruction
    input  wire logic              decode_valid_in,
    input  wire logic [15:0]       decode_op_in,
    input  wire logic              in_loop_in,
    input  wire logic [7:0]        loop_len_in,
    input  wire logic [7:0]        loop_pos_from_end_in,
    input  wire logic [ADDR_W-1:0] decode_pc_in,
    input  wire logic [ADDR_W-1:0] next_pc_in,
    input  wire logic [ADDR_W-1:0] branch_target_in,
    // Exception sources
    input  wire logic              addr_err_req_in,
    input  wire logic              irq_req_in,
    input  wire logic [7:0]        irq_vector_in,
    input  wire logic              trap_req_in,
    input  wire logic [7:0]        trap_vector_in,
    input  wire logic              illegal_req_in,
    input  wire logic              slot_illegal_req_in,
    input  wire logic [7:0]        instr_vector_in,
    // Core state
    input  wire logic [31:0]       saved_status_word_in,
    input  wire logic [ADDR_W-1:0] stack_top_pointer_in,
    input  wire logic [ADDR_W-1:0] vector_table_base_in,
    // Memory port
    output logic                   mem_wr_out,
    output logic                   mem_rd_out,
    output logic [ADDR_W-1:0]      mem_addr_out,
    output logic [31:0]            mem_wdata_out,
    input  wire logic [31:0]       mem_rdata_in,
    // Core updates
    output logic                   busy_out,
    output logic                   sp_load_out,
    output logic [ADDR_W-1:0]      sp_value_out,
    output logic                   pc_load_out,
    output logic [ADDR_W-1:0]      pc_value_out,
    output logic                   irq_ack_out,
    output logic [2:0]             kind_out
);
    initial begin
        if (ADDR_W != 32) begin
            $error("eas_exception_unit supports a 32-bit address only");
        end
    end

    eas_gate_if gate_bus ();

    logic is_delayed;
    logic is_int_dis;
    logic [15:0] op;

    assign op = decode_op_in;

    // Delayed branch class
    always_comb begin
        is_delayed = 1'b0;
        if (op[15:12] == 4'hA || op[15:12] == 4'hB) begin
            is_delayed = 1'b1;
        end
        if (op[15:8] == 8'h8D || op[15:8] == 8'h8F) begin
            is_delayed = 1'b1;
        end
        if (op[15:12] == 4'h4 && (op[7:0] == 8'h2B || op[7:0] == 8'h0B)) begin
            is_delayed = 1'b1;
        end
        if (op[15:12] == 4'h0 && (op[7:0] == 8'h23 || op[7:0] == 8'h03)) begin
            is_delayed = 1'b1;
        end
        if (op == 16'h000B || op == 16'h002B) begin
            is_delayed = 1'b1;
        end
    end

    // Control and system register loads and stores
    always_comb begin
        is_int_dis = 1'b0;
        if (op[15:12] == 4'h4 && op[3:0] inside {4'hE, 4'h7, 4'hA, 4'h6}) begin
            is_int_dis = 1'b1;
        end
        if (op[15:12] == 4'h4 && op[3:0] inside {4'h3, 4'h2}) begin
            is_int_dis = 1'b1;
        end
        if (op[15:12] == 4'h0 && op[3:0] inside {4'h2, 4'hA}) begin
            is_int_dis = 1'b1;
        end
    end

    assign gate_bus.decode_valid      = decode_valid_in;
    assign gate_bus.is_delayed_branch = is_delayed;
    assign gate_bus.is_int_disabled   = is_int_dis;
    assign gate_bus.in_loop           = in_loop_in;
    assign gate_bus.loop_len          = loop_len_in;
    assign gate_bus.loop_pos_from_end = loop_pos_from_end_in;

    eas_accept_gate u_gate (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .gate_io    (gate_bus.gate)
    );

    eas_pkg::eas_state_t state;
    logic              pend_ae;
    logic              pend_irq;
    logic              defer_ae;
    logic              suppress_ae;
    logic [2:0]        kind;
    logic [7:0]        vec_num;
    logic [ADDR_W-1:0] save_pc;
    logic [ADDR_W-1:0] sp;
    logic              stack_fault;
    logic              take_ae;
    logic              take_irq;
    logic              take_instr;
    logic              slot_ok;
    logic              misaligned_sp;
    logic [ADDR_W-1:0] vec_addr;

    assign slot_ok = decode_valid_in && !is_delayed;
    assign take_instr = (state == eas_pkg::EAS_IDLE) && decode_valid_in &&
                        (trap_req_in || illegal_req_in ||
                         slot_illegal_req_in);
    assign take_ae  = (state == eas_pkg::EAS_IDLE) && slot_ok && !take_instr &&
                      (pend_ae || defer_ae) &&
                      !gate_bus.block_addr_err;
    assign take_irq = (state == eas_pkg::EAS_IDLE) && slot_ok && !take_instr &&
                      !take_ae && pend_irq && !gate_bus.block_irq;
    assign misaligned_sp = |(stack_top_pointer_in[1:0] & eas_pkg::ALIGN_MASK);
    assign vec_addr = vector_table_base_in +
                      {22'h000000, vec_num, 2'h0};

    // Pending flags; a new request wins over the clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pend_ae  <= 1'b0;
            pend_irq <= 1'b0;
        end else if (clk_en_in) begin
            pend_ae  <= addr_err_req_in | (pend_ae & ~take_ae);
            pend_irq <= irq_req_in | (pend_irq & ~take_irq);
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state       <= eas_pkg::EAS_IDLE;
            kind        <= eas_pkg::KIND_ADDR_ERR;
            vec_num     <= 8'h00;
            save_pc     <= eas_pkg::RESET_WORD;
            sp          <= eas_pkg::RESET_WORD;
            stack_fault <= 1'b0;
            defer_ae    <= 1'b0;
            suppress_ae <= 1'b0;
        end else if (clk_en_in) begin
            case (state)
                eas_pkg::EAS_IDLE: begin
                    stack_fault <= 1'b0;
                    sp <= stack_top_pointer_in;
                    if (take_instr) begin
                        state <= eas_pkg::EAS_PUSH_STAT;
                        suppress_ae <= 1'b0;
                        vec_num <= trap_req_in ? trap_vector_in
                                               : instr_vector_in;
                        if (slot_illegal_req_in) begin
                            kind    <= eas_pkg::KIND_SLOT;
                            save_pc <= branch_target_in;
                        end else if (trap_req_in) begin
                            kind    <= eas_pkg::KIND_TRAP;
                            save_pc <= next_pc_in;
                        end else begin
                            kind    <= eas_pkg::KIND_ILLEGAL;
                            save_pc <= decode_pc_in;
                        end
                    end else if (take_ae) begin
                        state       <= eas_pkg::EAS_PUSH_STAT;
                        kind        <= eas_pkg::KIND_ADDR_ERR;
                        vec_num     <= eas_pkg::ADDR_ERR_VEC;
                        save_pc     <= decode_pc_in;
                        suppress_ae <= defer_ae;
                        defer_ae    <= 1'b0;
                    end else if (take_irq) begin
                        state       <= eas_pkg::EAS_PUSH_STAT;
                        kind        <= eas_pkg::KIND_IRQ;
                        vec_num     <= irq_vector_in;
                        save_pc     <= decode_pc_in;
                        suppress_ae <= 1'b0;
                    end
                end
                eas_pkg::EAS_PUSH_STAT: begin
                    sp <= sp - eas_pkg::STACK_STEP;
                    if (|(sp[1:0] & eas_pkg::ALIGN_MASK)) begin
                        stack_fault <= 1'b1;
                    end
                    state <= eas_pkg::EAS_PUSH_PC;
                end
                eas_pkg::EAS_PUSH_PC: begin
                    sp    <= sp - eas_pkg::STACK_STEP;
                    state <= eas_pkg::EAS_VEC_READ;
                end
                eas_pkg::EAS_VEC_READ: begin
                    if (|(vector_table_base_in[1:0] & eas_pkg::ALIGN_MASK))
                    begin
                        stack_fault <= 1'b1;
                    end
                    state <= eas_pkg::EAS_JUMP;
                end
                eas_pkg::EAS_JUMP: begin
                    state <= eas_pkg::EAS_DONE;
                end
                eas_pkg::EAS_DONE: begin
                    if (stack_fault && !suppress_ae) begin
                        defer_ae <= 1'b1;
                    end
                    suppress_ae <= 1'b0;
                    state <= eas_pkg::EAS_IDLE;
                end
                default: begin
                    state <= eas_pkg::EAS_IDLE;
                end
            endcase
        end
    end

    // Memory and core outputs, all registered
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mem_wr_out    <= 1'b0;
            mem_rd_out    <= 1'b0;
            mem_addr_out  <= eas_pkg::RESET_WORD;
            mem_wdata_out <= eas_pkg::RESET_WORD;
            sp_load_out   <= 1'b0;
            sp_value_out  <= eas_pkg::RESET_WORD;
            pc_load_out   <= 1'b0;
            pc_value_out  <= eas_pkg::RESET_WORD;
            irq_ack_out   <= 1'b0;
            busy_out      <= 1'b0;
            kind_out      <= eas_pkg::KIND_ADDR_ERR;
        end else if (clk_en_in) begin
            mem_wr_out  <= 1'b0;
            mem_rd_out  <= 1'b0;
            sp_load_out <= 1'b0;
            pc_load_out <= 1'b0;
            irq_ack_out <= take_irq;
            busy_out    <= (state != eas_pkg::EAS_IDLE) ||
                           take_instr || take_ae || take_irq;
            kind_out    <= kind;
            case (state)
                eas_pkg::EAS_PUSH_STAT: begin
                    mem_wr_out    <= 1'b1;
                    mem_addr_out  <= sp - eas_pkg::STACK_STEP;
                    mem_wdata_out <= saved_status_word_in;
                end
                eas_pkg::EAS_PUSH_PC: begin
                    mem_wr_out    <= 1'b1;
                    mem_addr_out  <= sp - eas_pkg::STACK_STEP;
                    mem_wdata_out <= save_pc;
                    sp_load_out   <= 1'b1;
                    sp_value_out  <= sp - eas_pkg::STACK_STEP;
                end
                eas_pkg::EAS_VEC_READ: begin
                    mem_rd_out   <= 1'b1;
                    mem_addr_out <= vec_addr;
                end
                eas_pkg::EAS_DONE: begin
                    pc_load_out  <= 1'b1;
                    pc_value_out <= mem_rdata_in;
                end
                default: begin
                    mem_wr_out <= 1'b0;
                end
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = misaligned_sp;
endmodule

// [eas_exception_unit_props.sv]
// Checker: stacking order and acceptance timing of the exception unit.
// Assumes the clock enable stays high while it watches.
`timescale 1ns/100ps
module eas_exception_unit_props #(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input wire logic              ref_clk_in,
    input wire logic              sys_rst_in,
    // Decode and core state
    input wire logic              decode_valid_in,
    input wire logic [15:0]       decode_op_in,
    input wire logic [31:0]       saved_status_word_in,
    input wire logic [ADDR_W-1:0] stack_top_pointer_in,
    input wire logic [31:0]       mem_rdata_in,
    // Watched outputs
    input wire logic              mem_wr_out,
    input wire logic              mem_rd_out,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic [31:0]       mem_wdata_out,
    input wire logic              busy_out,
    input wire logic              sp_load_out,
    input wire logic [ADDR_W-1:0] sp_value_out,
    input wire logic              pc_load_out,
    input wire logic [ADDR_W-1:0] pc_value_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_take_on_decode: assert property (
        $rose(busy_out) |-> $past(decode_valid_in))
        else $error("Handling began without a decode");
    a_branch_no_take: assert property (
        decode_valid_in && !busy_out && decode_op_in[15:13] == 3'h5
        |=> !busy_out)
        else $error("Handling began on a delayed branch");
    a_stack_order: assert property (
        $rose(busy_out) |=> mem_wr_out && !sp_load_out
        ##1 mem_wr_out && sp_load_out ##1 mem_rd_out && !mem_wr_out)
        else $error("Status, pc and vector accesses out of order");
    a_wr_pair: assert property (
        mem_wr_out && !sp_load_out |=> mem_wr_out && sp_load_out
        && mem_addr_out == $past(mem_addr_out) - eas_pkg::STACK_STEP)
        else $error("Second stack write not four below the first");
    a_sp_value: assert property (
        sp_load_out |-> sp_value_out == stack_top_pointer_in - 32'h8
        && mem_addr_out == sp_value_out)
        else $error("Stack pointer update does not match write address");
    a_status_data: assert property (
        mem_wr_out && !sp_load_out && mem_addr_out[1:0] == 2'h0
        |-> mem_wdata_out == saved_status_word_in)
        else $error("First stack write is not the status word");
    a_vec_after_pc: assert property (
        $rose(mem_rd_out) |-> $past(sp_load_out) && $past(mem_wr_out))
        else $error("Vector read not right after the pc write");
    a_handler_jump: assert property (
        mem_rd_out |-> ##2 pc_load_out && pc_value_out == mem_rdata_in)
        else $error("Handler address not loaded two cycles after read");
    a_busy_span: assert property (
        $rose(busy_out) |-> busy_out[*6] ##1 (!busy_out && $past(pc_load_out)))
        else $error("Busy span wrong or no direct jump at the end");
endmodule

bind eas_exception_unit eas_exception_unit_props #(.ADDR_W(ADDR_W)) u_props (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .decode_valid_in(decode_valid_in), .decode_op_in(decode_op_in),
    .saved_status_word_in(saved_status_word_in),
    .stack_top_pointer_in(stack_top_pointer_in),
    .mem_rdata_in(mem_rdata_in), .mem_wr_out(mem_wr_out),
    .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .busy_out(busy_out),
    .sp_load_out(sp_load_out), .sp_value_out(sp_value_out),
    .pc_load_out(pc_load_out), .pc_value_out(pc_value_out)
);

// [tb_eas_exception_unit.sv]
// Testbench: acceptance gating and stack frames of the exception unit.
// Assumes the hand-over timing and classic 16-bit opcode encodings.
`timescale 1ns/100ps
module tb_eas_exception_unit;
    localparam logic [31:0] HND = 32'h0000_3C40;
    localparam logic [31:0] SP0 = 32'h0000_2000;
    localparam logic [31:0] VB0 = 32'h0000_0400;
    localparam logic [15:0] NOP = 16'h0009;
    localparam logic [7:0]  IVEC = 8'h40;
    localparam logic [7:0]  TVEC = 8'h21;
    localparam logic [7:0]  XVEC = 8'h06;
    // Delayed branches, then control and system register accesses
    localparam logic [15:0] BR_OPS [10] = '{16'h402B, 16'h400B, 16'hA000,
        16'hB000, 16'h000B, 16'h002B, 16'h8D00, 16'h8F00, 16'h0003, 16'h0023};
    localparam logic [15:0] ID_OPS [8] = '{16'h400E, 16'h4007, 16'h0002,
        16'h4003, 16'h400A, 16'h4006, 16'h000A, 16'h4002};
    logic        ref_clk_in, sys_rst_in, clk_en_in, decode_valid_in;
    logic        in_loop_in, addr_err_req_in, irq_req_in, trap_req_in;
    logic        illegal_req_in, slot_illegal_req_in, ack_seen;
    logic [15:0] decode_op_in;
    logic [7:0]  loop_len_in, loop_pos_from_end_in;
    logic [31:0] decode_pc_in, next_pc_in, branch_target_in, pc_v;
    logic [31:0] saved_status_word_in, stack_top_pointer_in;
    logic [31:0] vector_table_base_in;
    logic        mem_wr_out, mem_rd_out, busy_out, sp_load_out;
    logic        pc_load_out, irq_ack_out;
    logic [31:0] mem_addr_out, mem_wdata_out, sp_value_out, pc_value_out;
    logic [2:0]  kind_out;
    int          n_errors, total_checks, cycles;

    eas_exception_unit dut (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .decode_valid_in(decode_valid_in),
        .decode_op_in(decode_op_in), .in_loop_in(in_loop_in),
        .loop_len_in(loop_len_in),
        .loop_pos_from_end_in(loop_pos_from_end_in),
        .decode_pc_in(decode_pc_in), .next_pc_in(next_pc_in),
        .branch_target_in(branch_target_in),
        .addr_err_req_in(addr_err_req_in), .irq_req_in(irq_req_in),
        .irq_vector_in(IVEC), .trap_req_in(trap_req_in),
        .trap_vector_in(TVEC), .illegal_req_in(illegal_req_in),
        .slot_illegal_req_in(slot_illegal_req_in), .instr_vector_in(XVEC),
        .saved_status_word_in(saved_status_word_in),
        .stack_top_pointer_in(stack_top_pointer_in),
        .vector_table_base_in(vector_table_base_in),
        .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(HND), .busy_out(busy_out),
        .sp_load_out(sp_load_out), .sp_value_out(sp_value_out),
        .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
        .irq_ack_out(irq_ack_out), .kind_out(kind_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // Hang guard and interrupt acknowledge watch
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (irq_ack_out === 1'b1) ack_seen <= 1'b1;
        if (cycles == 6000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic pulse(input logic irq);
        @(posedge ref_clk_in);
        addr_err_req_in <= !irq;
        irq_req_in <= irq;
        @(posedge ref_clk_in);
        addr_err_req_in <= 1'b0;
        irq_req_in <= 1'b0;
    endtask

    // One decode; exp 0 or 1 is the expected take, 2 leaves it open
    task automatic dec(input logic [15:0] op, input int exp, ins = 0,
            input logic lp = 1'b0, input logic [7:0] len = 8'h0,
            pos = 8'h0);
        @(posedge ref_clk_in);
        pc_v = pc_v + 32'h2;
        decode_valid_in <= 1'b1;
        decode_op_in <= op;
        in_loop_in <= lp;
        loop_len_in <= len;
        loop_pos_from_end_in <= pos;
        decode_pc_in <= pc_v;
        next_pc_in <= pc_v + 32'h2;
        if (ins != 3) branch_target_in <= pc_v + 32'h100;
        saved_status_word_in <= {16'hC35A, pc_v[15:0]};
        trap_req_in <= (ins == 1);
        illegal_req_in <= (ins == 2);
        slot_illegal_req_in <= (ins == 3);
        @(posedge ref_clk_in);
        decode_valid_in <= 1'b0;
        trap_req_in <= 1'b0;
        illegal_req_in <= 1'b0;
        slot_illegal_req_in <= 1'b0;
        #1;
        if (exp < 2) chk_bit(busy_out, exp[0]);
    endtask

    // Whole handling sequence; write data unchecked when misaligned
    task automatic frame(input logic [2:0] k, input logic [31:0] pcv,
            input logic [7:0] vec, input logic al);
        logic [31:0] sp;
        sp = stack_top_pointer_in;
        tick();
        chk_bit(mem_wr_out, 1'b1);
        chk_val(mem_addr_out, sp - 32'h4);
        if (al) chk_val(mem_wdata_out, saved_status_word_in);
        tick();
        chk_bit(sp_load_out, 1'b1);
        chk_val(sp_value_out, sp - 32'h8);
        chk_val(mem_addr_out, sp - 32'h8);
        if (al) chk_val(mem_wdata_out, pcv);
        tick();
        chk_bit(mem_rd_out, 1'b1);
        chk_val(mem_addr_out, vector_table_base_in + {vec, 2'h0});
        tick();
        tick();
        chk_bit(pc_load_out, 1'b1);
        chk_val(pc_value_out, HND);
        chk_val({29'h0, kind_out}, {29'h0, k});
        tick();
        chk_bit(busy_out, 1'b0);
    endtask

    task automatic ei(input logic irq, al);
        frame(irq ? eas_pkg::KIND_IRQ : eas_pkg::KIND_ADDR_ERR, decode_pc_in,
            irq ? IVEC : eas_pkg::ADDR_ERR_VEC, al);
    endtask

    task automatic t_kinds();
        dec(NOP, 0);
        pulse(1'b0);
        dec(NOP, 1);
        ei(1'b0, 1'b1);
        pulse(1'b1);
        dec(NOP, 1);
        ei(1'b1, 1'b1);
        chk_bit(ack_seen, 1'b1);
        dec(NOP, 1, 1);
        frame(eas_pkg::KIND_TRAP, next_pc_in, TVEC, 1'b1);
        dec(NOP, 1, 2);
        frame(eas_pkg::KIND_ILLEGAL, decode_pc_in, XVEC, 1'b1);
        dec(16'hA000, 0);
        dec(NOP, 1, 3);
        frame(eas_pkg::KIND_SLOT, branch_target_in, XVEC, 1'b1);
    endtask

    task automatic t_branch();
        foreach (BR_OPS[i]) begin
            pulse(i[0]);
            dec(BR_OPS[i], 0);
            dec(NOP, 0);
            dec(NOP, 1);
            ei(i[0], 1'b1);
        end
    endtask

    task automatic t_intdis();
        foreach (ID_OPS[i]) begin
            dec(ID_OPS[i], 0);
            pulse(i[0]);
            dec(NOP, i[0] ? 0 : 1);
            if (i[0]) dec(NOP, 1);
            ei(i[0], 1'b1);
        end
    endtask

    task automatic t_loop(input logic [7:0] len, input logic irq);
        logic [7:0] pos;
        dec(NOP, 0, 0, 1'b1, len, len);
        pulse(irq);
        for (int j = 2 * len - 1; j > 0; j--) begin
            pos = 8'((j - 1) % len + 1);
            dec(NOP, (irq || len < 8'h4) ? 0 : 2, 0, 1'b1, len, pos);
            if (busy_out === 1'b1) break;
        end
        if (!irq && len > 8'h3)
            chk_bit(loop_pos_from_end_in inside {8'h4, 8'h3}, 1'b1);
        if (busy_out !== 1'b1) dec(NOP, 2);
        if (busy_out !== 1'b1) dec(NOP, 1);
        ei(irq, 1'b1);
    endtask

    task automatic t_mis(input logic [31:0] sp, vb);
        @(posedge ref_clk_in);
        stack_top_pointer_in <= sp;
        vector_table_base_in <= vb;
        dec(NOP, 1, 1);
        frame(eas_pkg::KIND_TRAP, next_pc_in, TVEC, sp[1:0] == 2'h0);
        @(posedge ref_clk_in);
        vector_table_base_in <= VB0;
        dec(NOP, 1);
        ei(1'b0, sp[1:0] == 2'h0);
        dec(NOP, 0);
        @(posedge ref_clk_in);
        stack_top_pointer_in <= SP0;
    endtask

    // Reset in mid-handling, then a blocked first decode
    task automatic t_reset();
        dec(NOP, 1, 2);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk_bit(busy_out | mem_wr_out | sp_load_out, 1'b0);
        pulse(1'b0);
        dec(NOP, 0);
        dec(NOP, 1);
        ei(1'b0, 1'b1);
    endtask

    initial begin
        {clk_en_in, sys_rst_in} = 2'h3;
        {decode_valid_in, in_loop_in, addr_err_req_in, irq_req_in} = 4'h0;
        {trap_req_in, illegal_req_in, slot_illegal_req_in} = 3'h0;
        {ack_seen, decode_op_in, loop_len_in, loop_pos_from_end_in} = '0;
        {decode_pc_in, next_pc_in, branch_target_in} = '0;
        pc_v = 32'h0000_1000;
        saved_status_word_in = 32'h0;
        stack_top_pointer_in = SP0;
        vector_table_base_in = VB0;
        {n_errors, total_checks, cycles} = '0;
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk_bit(busy_out | mem_wr_out | mem_rd_out | pc_load_out, 1'b0);
        t_kinds();
        t_branch();
        t_intdis();
        t_loop(8'h3, 1'b0);
        t_loop(8'h5, 1'b1);
        t_loop(8'h5, 1'b0);
        t_mis(32'h0000_2002, VB0);
        t_mis(SP0, 32'h0000_0102);
        t_reset();
        end_of_test();
    end
endmodule
